// file: hdl/ubg_cfg.svh
// Register map, field positions, reset values and rate constants
`ifndef UBG_CFG_SVH
`define UBG_CFG_SVH
// Register offsets (byte addresses of 32-bit words)
`define UBG_DIV_LOW_OFS   8'h00
`define UBG_DIV_HIGH_OFS  8'h04
`define UBG_CTRL_OFS      8'h08
`define UBG_STAT_OFS      8'h0C
`define UBG_RXDATA_OFS    8'h10
// Control register fields
`define UBG_CTRL_WIDE_BIT   0
`define UBG_CTRL_HSPEED_BIT 1
`define UBG_CTRL_ABD_BIT    2
`define UBG_CTRL_WAKE_BIT   3
`define UBG_CTRL_SYNC_BIT   4
`define UBG_CTRL_OVF_BIT    5
// Status register fields
`define UBG_STAT_RXFLAG_BIT 0
`define UBG_STAT_IDLE_BIT   1
`define UBG_STAT_OVF_BIT    2
// Reset values
`define UBG_DIV_RST   16'h0000
`define UBG_CTRL_RST  8'h00
// Base clock prescales in oscillator cycles
`define UBG_PRE_SLOW  8'h40
`define UBG_PRE_MID   8'h10
`define UBG_PRE_FAST  8'h04
// Auto-baud clock is base clock divided by this
`define UBG_ABD_DIV   4'h8
// Number of rising edges that end the sync character
`define UBG_SYNC_EDGES 3'h5
`endif

// file: hdl/ubg_pkg.sv
// Types shared by the baud generator design files
package ubg_pkg;
  typedef enum logic [3:0] {
    UBG_IDLE  = 4'b0001,
    UBG_START = 4'b0010,
    UBG_COUNT = 4'b0100,
    UBG_WAKE  = 4'b1000
  } ubg_state_e;
  typedef logic [15:0] ubg_div_t;
endpackage : ubg_pkg

// file: hdl/ubg_prescaler.sv
// Base clock and auto-baud clock prescaler
`timescale 1ns/1ps
`include "ubg_cfg.svh"
module ubg_prescaler (
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  resetn,
  // Mode selects and prescaler restart
  input  wire logic  wide_divider_select,
  input  wire logic  high_speed_select,
  input  wire logic  sync_mode,
  input  wire logic  restart,
  // Tick outputs
  ubg_tick_if.src    ticks
);
  logic [7:0] pre_reg;
  logic [7:0] pre_len;
  logic [3:0] abd_reg;
  logic       hs_eff;

  // Synchronous mode ignores the high-speed select
  assign hs_eff = high_speed_select & ~sync_mode;

  always_comb begin
    unique case ({wide_divider_select, hs_eff})
      2'b00:   pre_len = `UBG_PRE_SLOW;
      2'b11:   pre_len = `UBG_PRE_FAST;
      default: pre_len = `UBG_PRE_MID;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre_reg <= 8'h00;
    end else if (restart || pre_reg >= pre_len - 8'h01) begin
      pre_reg <= 8'h00;
    end else begin
      pre_reg <= pre_reg + 8'h01;
    end
  end

  // Greater-or-equal so a shorter prescale takes effect without a wrap
  assign ticks.base_tick = (pre_reg >= pre_len - 8'h01) & ~restart;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      abd_reg <= 4'h0;
    end else if (restart) begin
      abd_reg <= 4'h0;
    end else if (ticks.base_tick) begin
      if (abd_reg == `UBG_ABD_DIV - 4'h1) begin
        abd_reg <= 4'h0;
      end else begin
        abd_reg <= abd_reg + 4'h1;
      end
    end
  end

  // One eighth of the base clock
  assign ticks.abd_tick = ticks.base_tick
                          & (abd_reg == `UBG_ABD_DIV - 4'h1);
endmodule : ubg_prescaler

// file: hdl/ubg_sync.sv
// Two-flop synchroniser for the receive line
`timescale 1ns/1ps
module ubg_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Line in and out
  input  wire logic din,
  output logic      dout
);
  logic meta_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= 1'b1;
      dout     <= 1'b1;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule : ubg_sync

// file: hdl/ubg_tick_if.sv
// Prescaler outputs shared between prescaler and top
`timescale 1ns/1ps
interface ubg_tick_if;
  logic base_tick;
  logic abd_tick;
  modport src (output base_tick, output abd_tick);
  modport dst (input base_tick, input abd_tick);
endinterface : ubg_tick_if

// file: hdl/ubg_top.sv
// Baud generator with auto-baud measurement and wake-on-break monitor
// Contract
// - Divider is 8-bit after reset, 16-bit when wide select is set.
// - Baud timer runs freely, period set by the divider pair.
// - Async prescale uses both selects; sync mode ignores high-speed.
// - Base clock is osc/64, /16 or /4 by the two selects.
// - Writing the divider pair clears the baud timer at once.
// - Setting auto-baud enable starts calibration; receiver held idle.
// - Count from first rising edge after start to fifth rising edge.
// - On finish count stays, enable clears, receive flag sets.
// - During auto-baud the pair counts as one 16-bit counter.
// - Auto-baud counter ticks at one eighth of the base clock.
// - Auto-baud count starts at one; software subtracts one.
// - Wake plus auto-baud measures the character after the break.
// - Counter overflow before fifth edge sets overflow and rx flag.
// - After overflow counting continues until the fifth edge.
// - Idle status is zero until fifth edge; flag sets again then.
// - Early auto-baud clear hands remaining edges to the receiver.
// - Wake enable disables reception; async mode only.
// - Falling edge is the wake event, sets rx flag; read clears.
// - Rising edge ending the break clears wake enable.
`timescale 1ns/1ps
`include "ubg_cfg.svh"
module ubg_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [31:0] rdata,
  // Serial line and receiver interface
  input  wire logic        receive_line,
  output logic             baud_tick,
  output logic             rx_enable,
  output logic             start_edge
);
  ubg_tick_if       ticks ();
  ubg_pkg::ubg_state_e state_reg;
  ubg_pkg::ubg_div_t   div_reg;
  ubg_pkg::ubg_div_t   cnt_reg;
  logic       wide_divider_select;
  logic       high_speed_select;
  logic       autobaud_enable;
  logic       wake_on_break_enable;
  logic       sync_mode;
  logic       autobaud_overflow_flag;
  logic       receive_interrupt_flag;
  logic       receiver_idle_status;
  logic [2:0] edge_reg;
  logic       rx_s;
  logic       rx_d_reg;
  logic       rise;
  logic       fall;
  logic       div_wr;
  logic       ctrl_wr;
  logic       data_rd;
  logic       abd_done;
  logic       abd_ovf;
  logic       wake_hit;
  logic       wake_end;
  logic       ovf_pend_reg;
  logic [15:0] period;

  //----------------------------------------------------------------
  // Receive line conditioning
  //----------------------------------------------------------------
  ubg_sync u_sync (
    .clk    (clk),
    .resetn (resetn),
    .din    (receive_line),
    .dout   (rx_s)
  );

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_d_reg <= 1'b1;
    end else begin
      rx_d_reg <= rx_s;
    end
  end

  assign rise = rx_s & ~rx_d_reg;
  assign fall = ~rx_s & rx_d_reg;

  //----------------------------------------------------------------
  // Register decode
  //----------------------------------------------------------------
  assign div_wr  = wr_en & (addr == `UBG_DIV_LOW_OFS
                            || addr == `UBG_DIV_HIGH_OFS);
  assign ctrl_wr = wr_en & (addr == `UBG_CTRL_OFS);
  assign data_rd = rd_en & (addr == `UBG_RXDATA_OFS);

  //----------------------------------------------------------------
  // Prescaler
  //----------------------------------------------------------------
  ubg_prescaler u_pre (
    .clk                 (clk),
    .resetn              (resetn),
    .wide_divider_select (wide_divider_select),
    .high_speed_select   (high_speed_select),
    .sync_mode           (sync_mode),
    .restart             (div_wr),
    .ticks               (ticks.src)
  );

  //----------------------------------------------------------------
  // Measurement and wake state machine
  //----------------------------------------------------------------
  // First rise is taken in START, so the fourth rise in COUNT is the fifth
  assign abd_done = (state_reg == ubg_pkg::UBG_COUNT) & rise
                    & (edge_reg == `UBG_SYNC_EDGES - 3'h2);
  assign abd_ovf  = (state_reg == ubg_pkg::UBG_COUNT)
                    & ticks.abd_tick & (cnt_reg == 16'hFFFF);
  assign wake_hit = (state_reg == ubg_pkg::UBG_IDLE)
                    & wake_on_break_enable & ~sync_mode & fall;
  assign wake_end = (state_reg == ubg_pkg::UBG_WAKE) & rise;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ubg_pkg::UBG_IDLE;
    end else begin
      unique case (state_reg)
        ubg_pkg::UBG_IDLE: begin
          if (wake_hit) begin
            state_reg <= ubg_pkg::UBG_WAKE;
          end else if (autobaud_enable && !wake_on_break_enable
                       && fall) begin
            // Break first, then measure the next character
            state_reg <= ubg_pkg::UBG_START;
          end
        end
        ubg_pkg::UBG_START: begin
          if (!autobaud_enable) begin
            state_reg <= ubg_pkg::UBG_IDLE;
          end else if (rise) begin
            state_reg <= ubg_pkg::UBG_COUNT;
          end
        end
        ubg_pkg::UBG_COUNT: begin
          if (!autobaud_enable || abd_done) begin
            state_reg <= ubg_pkg::UBG_IDLE;
          end
        end
        ubg_pkg::UBG_WAKE: begin
          if (wake_end) begin
            state_reg <= ubg_pkg::UBG_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      edge_reg <= 3'h0;
    end else if (state_reg != ubg_pkg::UBG_COUNT) begin
      edge_reg <= 3'h0;
    end else if (rise) begin
      edge_reg <= edge_reg + 3'h1;
    end
  end

  // Count begins at one; wraps on overflow and keeps going
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 16'h0000;
    end else if (state_reg != ubg_pkg::UBG_COUNT) begin
      cnt_reg <= 16'h0001;
    end else if (ticks.abd_tick) begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  //----------------------------------------------------------------
  // Control register
  //----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wide_divider_select <= 1'b0;
      high_speed_select   <= 1'b0;
      sync_mode           <= 1'b0;
    end else if (ctrl_wr) begin
      wide_divider_select <= wdata[`UBG_CTRL_WIDE_BIT];
      high_speed_select   <= wdata[`UBG_CTRL_HSPEED_BIT];
      sync_mode           <= wdata[`UBG_CTRL_SYNC_BIT];
    end
  end

  // Hardware clear wins over a same-cycle software write
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      autobaud_enable <= 1'b0;
    end else if (abd_done) begin
      autobaud_enable <= 1'b0;
    end else if (ctrl_wr) begin
      autobaud_enable <= wdata[`UBG_CTRL_ABD_BIT];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wake_on_break_enable <= 1'b0;
    end else if (wake_end) begin
      wake_on_break_enable <= 1'b0;
    end else if (ctrl_wr) begin
      wake_on_break_enable <= wdata[`UBG_CTRL_WAKE_BIT];
    end
  end

  // Overflow flag: set wins over the software clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      autobaud_overflow_flag <= 1'b0;
    end else if (abd_ovf) begin
      autobaud_overflow_flag <= 1'b1;
    end else if (ctrl_wr && !wdata[`UBG_CTRL_OVF_BIT]) begin
      autobaud_overflow_flag <= 1'b0;
    end
  end

  // Remembers an overflow so the cover can see the fifth edge that follows it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ovf_pend_reg <= 1'b0;
    end else if (abd_ovf) begin
      ovf_pend_reg <= 1'b1;
    end else if (state_reg != ubg_pkg::UBG_COUNT) begin
      ovf_pend_reg <= 1'b0;
    end
  end

  //----------------------------------------------------------------
  // Receive flag: any set wins over the read that clears it
  //----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      receive_interrupt_flag <= 1'b0;
    end else if (abd_done || abd_ovf || wake_hit) begin
      receive_interrupt_flag <= 1'b1;
    end else if (data_rd) begin
      receive_interrupt_flag <= 1'b0;
    end
  end

  // Not idle from measurement start until the fifth edge
  assign receiver_idle_status = (state_reg == ubg_pkg::UBG_IDLE)
                                | (state_reg == ubg_pkg::UBG_WAKE);

  //----------------------------------------------------------------
  // Divider pair and free-running baud timer
  //----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_reg <= `UBG_DIV_RST;
    end else if (abd_done) begin
      div_reg <= cnt_reg;
    end else if (wr_en && addr == `UBG_DIV_LOW_OFS) begin
      div_reg[7:0] <= wdata[7:0];
    end else if (wr_en && addr == `UBG_DIV_HIGH_OFS) begin
      div_reg[15:8] <= wdata[7:0];
    end
  end

  // Narrow mode uses only the low byte
  assign period = wide_divider_select ? div_reg
                                      : {8'h00, div_reg[7:0]};

  ubg_pkg::ubg_div_t brg_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      brg_reg <= 16'h0000;
    end else if (div_wr) begin
      brg_reg <= 16'h0000;
    end else if (ticks.base_tick) begin
      if (brg_reg >= period) begin
        brg_reg <= 16'h0000;
      end else begin
        brg_reg <= brg_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      baud_tick <= 1'b0;
    end else begin
      baud_tick <= ticks.base_tick & ~div_wr
                   & (brg_reg >= period);
    end
  end

  // Receiver held off during measurement and while waiting for wake
  assign rx_enable  = (state_reg == ubg_pkg::UBG_IDLE) & ~autobaud_enable
                      & ~wake_on_break_enable;
  assign start_edge = rx_enable & fall;

  //----------------------------------------------------------------
  // Read port
  //----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 32'h0000_0000;
    end else if (rd_en) begin
      unique case (addr)
        `UBG_DIV_LOW_OFS:  rdata <= {24'h000000, div_reg[7:0]};
        `UBG_DIV_HIGH_OFS: rdata <= {24'h000000, div_reg[15:8]};
        `UBG_CTRL_OFS:     rdata <= {26'h0, autobaud_overflow_flag,
                                     sync_mode, wake_on_break_enable,
                                     autobaud_enable, high_speed_select,
                                     wide_divider_select};
        `UBG_STAT_OFS:     rdata <= {29'h0, autobaud_overflow_flag,
                                     receiver_idle_status,
                                     receive_interrupt_flag};
        default:           rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  //----------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------
  chk_div_clear: assert property (@(posedge clk) disable iff (!resetn)
    div_wr |=> brg_reg == 16'h0000)
    else $error("baud timer not cleared by divider write");
  chk_abd_result: assert property (@(posedge clk) disable iff (!resetn)
    abd_done |=> div_reg == $past(cnt_reg) && !autobaud_enable
                 && receive_interrupt_flag)
    else $error("auto-baud result not stored");
  chk_ovf_flag: assert property (@(posedge clk) disable iff (!resetn)
    abd_ovf |=> autobaud_overflow_flag && receive_interrupt_flag
                && cnt_reg == 16'h0000)
    else $error("overflow not reported");
  chk_idle_low: assert property (@(posedge clk) disable iff (!resetn)
    state_reg == ubg_pkg::UBG_COUNT |-> !receiver_idle_status)
    else $error("idle status set during measurement");
  chk_wake_end: assert property (@(posedge clk) disable iff (!resetn)
    wake_end |=> !wake_on_break_enable)
    else $error("wake enable not cleared at break end");
  chk_rx_held: assert property (@(posedge clk) disable iff (!resetn)
    (autobaud_enable || wake_on_break_enable) |-> !rx_enable)
    else $error("receiver enabled while held");
  chk_wake_flag: assert property (@(posedge clk) disable iff (!resetn)
    wake_hit |=> receive_interrupt_flag
                 && state_reg == ubg_pkg::UBG_WAKE)
    else $error("wake event not flagged");
  chk_narrow_mode: assert property (@(posedge clk) disable iff (!resetn)
    !wide_divider_select |-> period[15:8] == 8'h00)
    else $error("narrow mode uses high byte");
  chk_count_start: assert property (@(posedge clk) disable iff (!resetn)
    $rose(state_reg == ubg_pkg::UBG_COUNT) |-> cnt_reg == 16'h0001)
    else $error("auto-baud count not started at one");
  cov_abd_done: cover property (@(posedge clk) disable iff (!resetn)
    abd_done);
  cov_abd_ovf: cover property (@(posedge clk) disable iff (!resetn)
    abd_ovf);
  cov_wake: cover property (@(posedge clk) disable iff (!resetn)
    wake_hit ##[1:1000] wake_end);
  cov_tick: cover property (@(posedge clk) disable iff (!resetn)
    baud_tick);
  cov_ovf_redo: cover property (@(posedge clk) disable iff (!resetn)
    ovf_pend_reg && abd_done);
endmodule : ubg_top

// file: test/ubg_remote_tx.sv
// Remote asynchronous transmitter model driving the receive line
`timescale 1ns/1ps
module ubg_remote_tx (
  // Clock
  input  wire logic clk,
  // Serial line, idle high
  output logic      receive_line
);
  initial receive_line = 1'b1;

  // Hold the line at one level for n clock cycles
  task automatic drive(input logic v, input int n);
    receive_line <= v;
    repeat (n) @(posedge clk);
  endtask : drive

  // Start bit, eight data bits lowest first, stop bit
  task automatic send_byte(input logic [7:0] dat, input int bt);
    drive(1'b0, bt);
    for (int i = 0; i < 8; i++) drive(dat[i], bt);
    drive(1'b1, bt);
  endtask : send_byte

  // Wake-up character of all zeros, then one idle bit time
  task automatic send_break(input int nb, input int bt);
    drive(1'b0, nb * bt);
    drive(1'b1, bt);
  endtask : send_break
endmodule : ubg_remote_tx

// file: test/ubg_top_tb.sv
// Self-checking bench for the baud generator block
`timescale 1ns/1ps
`include "ubg_cfg.svh"
module ubg_top_tb;
  logic        clk    = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  addr   = 8'h00;
  logic [31:0] wdata  = 32'h0000_0000;
  logic        wr_en  = 1'b0;
  logic        rd_en  = 1'b0;
  logic [31:0] rdata;
  logic        receive_line;
  logic        baud_tick;
  logic        rx_enable;
  logic        start_edge;
  logic [31:0] d;
  int          n_fail    = 0;
  int          tests_run = 0;
  int          n;
  // Tick spacing in cycles for each control setting of the period loop
  int          exp_per [5] = '{256, 4160, 64, 1040, 256};

  always #20 clk = ~clk;

  ubg_top uut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .receive_line(receive_line), .baud_tick(baud_tick),
    .rx_enable(rx_enable), .start_edge(start_edge));
  ubg_remote_tx rtx (.clk(clk), .receive_line(receive_line));

  // ----------------------------------------
  // Bus access and checking
  // ----------------------------------------
  task automatic report_and_stop();
    if (n_fail == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 v = rdata;
  endtask : rd

  // Cycles up to the next tick; a lost tick ends the run
  task automatic wait_tick(output int c);
    c = 0;
    do begin
      @(posedge clk);
      #1 c++;
    end while (baud_tick !== 1'b1 && c < 20000);
    if (c >= 20000) begin
      n_fail++;
      report_and_stop();
    end
  endtask : wait_tick

  // Measured count may land one below the nominal, by prescaler phase
  task automatic check_abd(input int e);
    logic [31:0] lo;
    logic [31:0] hi;
    rd(`UBG_CTRL_OFS, d);
    chk("abd_ctrl", 32'h2, d);
    rd(`UBG_STAT_OFS, d);
    chk("abd_stat", 32'h3, d);
    rd(`UBG_DIV_LOW_OFS, lo);
    rd(`UBG_DIV_HIGH_OFS, hi);
    n = {hi[7:0], lo[7:0]};
    chk("abd_count", 1, n >= e - 1 && n <= e);
    rd(`UBG_RXDATA_OFS, d);
    chk("rxdata", 0, d);
    rd(`UBG_STAT_OFS, d);
    chk("flag_clear", 32'h2, d);
  endtask : check_abd

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    rd(`UBG_CTRL_OFS, d);
    chk("ctrl_rst", 0, d);
    rd(`UBG_DIV_HIGH_OFS, d);
    chk("div_rst", 0, d);
    rd(`UBG_STAT_OFS, d);
    chk("stat_rst", 32'h2, d);
    rd(8'h14, d);
    chk("unmapped", 0, d);
    // High byte must be ignored while narrow
    wr(`UBG_DIV_HIGH_OFS, 32'h1);
    wr(`UBG_DIV_LOW_OFS, 32'h3);
    for (int i = 0; i < 5; i++) begin
      wr(`UBG_CTRL_OFS, (i == 4) ? 32'h12 : i);
      wait_tick(n);
      wait_tick(n);
      chk("tick_period", exp_per[i], n);
    end
    // A long count must not delay the new rate
    wr(`UBG_CTRL_OFS, 32'h1);
    wr(`UBG_DIV_LOW_OFS, 32'hFF);
    wr(`UBG_DIV_HIGH_OFS, 32'hFF);
    repeat (100) @(posedge clk);
    wr(`UBG_DIV_HIGH_OFS, 32'h0);
    wr(`UBG_DIV_LOW_OFS, 32'h3);
    wait_tick(n);
    chk("restart", 1, n >= 60 && n <= 70);
    // Narrow mode calibration longer than one byte
    wr(`UBG_CTRL_OFS, 32'h6);
    #1 chk("rx_en_abd", 0, rx_enable);
    fork
      rtx.send_byte(8'h55, 4160);
      begin
        repeat (9000) @(posedge clk);
        rd(`UBG_STAT_OFS, d);
        chk("idle_busy", 0, d[1]);
        chk("rx_en_busy", 0, rx_enable);
      end
    join
    repeat (8) @(posedge clk);
    check_abd(261);
    // Wake on break
    wr(`UBG_CTRL_OFS, 32'h8);
    rtx.drive(1'b0, 100);
    rd(`UBG_STAT_OFS, d);
    chk("wake_flag", 1, d[0]);
    chk("wake_rx_en", 0, rx_enable);
    rd(`UBG_CTRL_OFS, d);
    chk("wake_held", 1, d[3]);
    rtx.drive(1'b0, 2000);
    rtx.drive(1'b1, 50);
    rd(`UBG_CTRL_OFS, d);
    chk("wake_end", 0, d);
    rd(`UBG_RXDATA_OFS, d);
    rd(`UBG_STAT_OFS, d);
    chk("wake_clr", 32'h2, d);
    // Calibration must skip the break and measure the next character
    wr(`UBG_CTRL_OFS, 32'hE);
    rtx.send_break(13, 160);
    rd(`UBG_RXDATA_OFS, d);
    rtx.send_byte(8'h55, 160);
    repeat (8) @(posedge clk);
    check_abd(11);
    // Early abort hands later falling edges to the receiver
    wr(`UBG_CTRL_OFS, 32'h4);
    rtx.drive(1'b0, 160);
    rtx.drive(1'b1, 160);
    wr(`UBG_CTRL_OFS, 32'h0);
    // The state machine leaves COUNT one edge after the enable drops
    @(posedge clk);
    #1 chk("rx_en_abort", 1, rx_enable);
    fork
      rtx.drive(1'b0, 40);
      begin
        n = 0;
        do begin
          @(posedge clk);
          #1 n++;
        end while (start_edge !== 1'b1 && n < 30);
        chk("start_edge", 1, n < 30);
      end
    join
    report_and_stop();
  end
endmodule : ubg_top_tb
